// ==== dit_top.sv ====
/*
 dual interval timer with interrupt mask and destination routing,
 reached over an avalon-mm slave with waitrequest.
 assumes the six other interrupt sources arrive as synchronous levels.
*/
// Decided for this implementation: register access over Avalon-MM.
// Contract
// - timer irq only while enable bit set; a raised request stays after the enable bit clears, until the clear bit
// - eight-bit threshold counts resolution steps
// - threshold zero means 256 steps
// - secondary chain divides base ticks by 100
// - secondary count readable, top bit reserved
// - final count readable, expires on match
// - expiry sets flag, and status if enabled
// - run bit advances, zero freezes chains
// - clear bit holds chains cleared
// - clear bit drops flag and request
// - prescale one gives 0.5 ms steps
// - prescale zero bypasses, 5 us steps
// - mask bit one enables status bit
// - fixed mapping of eight source bits
// - destination one input 1, zero input 0
// - one steering bit per source
// - written one forces, clear removes forced
// - timer interrupt suspends dma
`timescale 1ns/1ps
`default_nettype none
module dit_top (
    input  wire logic        clk,               // 40 MHz system clock
    input  wire logic        rst,               // synchronous reset
    input  wire logic [17:0] avs_address,       // byte address
    input  wire logic        avs_read,          // read request
    input  wire logic        avs_write,         // write request
    input  wire logic [31:0] avs_writedata,     // write data
    input  wire logic [3:0]  avs_byteenable,    // byte lanes
    output logic      [31:0] avs_readdata,      // read data
    output logic             avs_waitrequest,   // stall
    output logic      [1:0]  avs_response,      // 00 ok, 10 slave error
    input  wire logic [7:0]  source_irq,        // external sources
    output logic             mcu_irq_zero,      // core interrupt input 0
    output logic             mcu_irq_one,       // core interrupt input 1
    output logic             dma_suspend        // hold dma off the bus
);
    // primary prescale count width
    localparam int PW = $clog2(dit_pkg::BASE_DIV);
    localparam logic [PW-1:0] PRE_LAST = PW'(dit_pkg::BASE_DIV - 1);

    // bus handshake states, gray along idle-answer-done
    typedef enum logic [1:0] {
        DIT_IDLE = 2'b00,
        DIT_ANS  = 2'b01,
        DIT_DONE = 2'b11
    } dit_bus_type;

    // all top-level state
    typedef struct packed {
        dit_bus_type   bus;
        logic [PW-1:0] pre;
        logic          tick;
        logic [7:0]    ctl1;
        logic [7:0]    ctl2;
        logic [7:0]    th1;
        logic [7:0]    th2;
        logic [7:0]    mask;
        logic [7:0]    dest;
        logic [7:0]    forced;
        logic [7:0]    pend1;
        logic [7:0]    pend2;
        logic [31:0]   rdata;
        logic [1:0]    resp;
        logic          irq0;
        logic          irq1;
        logic          susp;
        logic          waitreq;
    } dit_top_type;

    dit_top_type st;        // registered state
    dit_top_type next_st;   // next state
    logic [6:0]  sec1;      // timer one secondary chain
    logic [6:0]  sec2;      // timer two secondary chain
    logic [7:0]  fin1;      // timer one final chain
    logic [7:0]  fin2;      // timer two final chain
    logic        exp1;      // timer one expired flag
    logic        exp2;      // timer two expired flag
    logic        hit1;      // timer one expiry strobe
    logic        hit2;      // timer two expiry strobe
    logic [7:0]  status;    // live status byte
    logic [15:0] idx;       // word index of access
    logic [7:0]  wbyte;     // low write byte
    logic        wr_ok;     // low lane enabled
    logic [7:0]  rbyte;     // byte read back
    logic        hit_map;   // index is mapped
    logic [7:0]  routed;    // masked status
    logic        want_one;  // expected level on input one
    logic        want_zero; // expected level on input zero

    assign idx   = avs_address[17:2];
    assign wbyte = avs_writedata[7:0];
    assign wr_ok = avs_byteenable[0];

    // timer one
    dit_timer u_timer_one (
        .clk          (clk),
        .rst          (rst),
        .base_tick    (st.tick),
        .run_bit      (st.ctl1[dit_pkg::CTL_RUN]),
        .clear_bit    (st.ctl1[dit_pkg::CTL_CLEAR]),
        .prescale_sel (st.ctl1[dit_pkg::CTL_PRESCALE]),
        .threshold    (st.th1),
        .sec_count    (sec1),
        .final_count  (fin1),
        .expired      (exp1),
        .expire_pulse (hit1)
    );

    // timer two
    dit_timer u_timer_two (
        .clk          (clk),
        .rst          (rst),
        .base_tick    (st.tick),
        .run_bit      (st.ctl2[dit_pkg::CTL_RUN]),
        .clear_bit    (st.ctl2[dit_pkg::CTL_CLEAR]),
        .prescale_sel (st.ctl2[dit_pkg::CTL_PRESCALE]),
        .threshold    (st.th2),
        .sec_count    (sec2),
        .final_count  (fin2),
        .expired      (exp2),
        .expire_pulse (hit2)
    );

    // status byte: sources, timer requests and forced bits
    always_comb begin
        status = source_irq | st.forced;
        status[dit_pkg::SRC_TIMER_ONE] = st.pend1[0]
            | st.forced[dit_pkg::SRC_TIMER_ONE];
        status[dit_pkg::SRC_TIMER_TWO] = st.pend2[0]
            | st.forced[dit_pkg::SRC_TIMER_TWO];
        routed = status & st.mask;
        want_one  = |(status & st.mask & st.dest);
        want_zero = |(status & st.mask & ~st.dest);
    end

    // read mux for the low byte
    always_comb begin
        rbyte   = dit_pkg::RST_BYTE;
        hit_map = 1'b1;
        case (idx)
            dit_pkg::IDX_STATUS:    rbyte = status;
            dit_pkg::IDX_T1_CTRL:   rbyte = {exp1, st.ctl1[6:0]};
            dit_pkg::IDX_T1_THRESH: rbyte = st.th1;
            dit_pkg::IDX_T1_SEC:    rbyte = {1'b0, sec1};
            dit_pkg::IDX_T1_FINAL:  rbyte = fin1;
            dit_pkg::IDX_T2_CTRL:   rbyte = {exp2, st.ctl2[6:0]};
            dit_pkg::IDX_T2_THRESH: rbyte = st.th2;
            dit_pkg::IDX_T2_SEC:    rbyte = {1'b0, sec2};
            dit_pkg::IDX_T2_FINAL:  rbyte = fin2;
            dit_pkg::IDX_MASK:      rbyte = st.mask;
            dit_pkg::IDX_DEST:      rbyte = st.dest;
            default:                hit_map = 1'b0;
        endcase
    end

    // next-state logic
    always_comb begin
        next_st = st;
        // base tick every 200 clocks
        next_st.tick = 1'b0;
        if (st.pre == PRE_LAST) begin
            next_st.pre  = '0;
            next_st.tick = 1'b1;
        end else begin
            next_st.pre = st.pre + PW'(1);
        end
        // bus: take in idle, answer next cycle, rest one cycle
        case (st.bus)
            DIT_IDLE: begin
                if (avs_read || avs_write) begin
                    next_st.bus   = DIT_ANS;
                    next_st.rdata = {24'h000000, rbyte};
                    next_st.resp  = hit_map ? 2'h0 : 2'h2;
                    if (avs_write && wr_ok) begin
                        case (idx)
                            dit_pkg::IDX_STATUS:
                                next_st.forced = wbyte;
                            dit_pkg::IDX_T1_CTRL:
                                next_st.ctl1 =
                                    wbyte & dit_pkg::CTL_WR_MASK;
                            dit_pkg::IDX_T1_THRESH:
                                next_st.th1 = wbyte;
                            dit_pkg::IDX_T2_CTRL:
                                next_st.ctl2 =
                                    wbyte & dit_pkg::CTL_WR_MASK;
                            dit_pkg::IDX_T2_THRESH:
                                next_st.th2 = wbyte;
                            dit_pkg::IDX_MASK:
                                next_st.mask = wbyte;
                            dit_pkg::IDX_DEST:
                                next_st.dest = wbyte;
                            default: ;
                        endcase
                    end
                end
            end
            DIT_ANS:  next_st.bus = DIT_DONE;
            DIT_DONE: next_st.bus = DIT_IDLE;
            default:  next_st.bus = DIT_IDLE;
        endcase
        // registered stall, low only in the answer cycle
        next_st.waitreq = (next_st.bus != DIT_ANS);
        // timer requests: set on enabled expiry, withdrawn by clear
        if (st.ctl1[dit_pkg::CTL_CLEAR]) begin
            next_st.pend1 = 8'h00;
        end
        if (hit1 && st.ctl1[dit_pkg::CTL_IRQ_EN]) begin
            next_st.pend1 = 8'h01;
        end
        if (st.ctl2[dit_pkg::CTL_CLEAR]) begin
            next_st.pend2 = 8'h00;
        end
        if (hit2 && st.ctl2[dit_pkg::CTL_IRQ_EN]) begin
            next_st.pend2 = 8'h01;
        end
        // routing to the two core inputs
        next_st.irq1 = |(routed & st.dest);
        next_st.irq0 = |(routed & ~st.dest);
        // suspend dma while a timer interrupt is delivered
        next_st.susp = routed[dit_pkg::SRC_TIMER_ONE]
            | routed[dit_pkg::SRC_TIMER_TWO];
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st     <= '0;
            st.bus <= DIT_IDLE;
            st.waitreq <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.waitreq;
    assign avs_response    = st.resp;
    assign mcu_irq_zero    = st.irq0;
    assign mcu_irq_one     = st.irq1;
    assign dma_suspend     = st.susp;

    // base tick spacing
    property p_tick_gap;
        @(posedge clk) disable iff (rst)
        st.tick |=> !st.tick [*8];
    endproperty
    a_tick_gap: assert property (p_tick_gap)
        else $error("base tick too frequent");

    // expiry with enable raises request
    property p_irq_on_expiry;
        @(posedge clk) disable iff (rst)
        hit1 && st.ctl1[0] && !st.ctl1[5] |=> st.pend1[0];
    endproperty
    a_irq_on_expiry: assert property (p_irq_on_expiry)
        else $error("timer one request missing");

    // no request without enable
    property p_no_irq_off;
        @(posedge clk) disable iff (rst)
        $rose(st.pend2[0]) |-> $past(st.ctl2[0]);
    endproperty
    a_no_irq_off: assert property (p_no_irq_off)
        else $error("timer two request without enable");

    // clear withdraws request and flag
    property p_clear_drops;
        @(posedge clk) disable iff (rst)
        st.ctl1[5] ##1 st.ctl1[5] ##1 st.ctl1[5] |-> !st.pend1[0] && !exp1;
    endproperty
    a_clear_drops: assert property (p_clear_drops)
        else $error("clear did not drop timer one");

    // clear holds chains zero
    property p_clear_holds;
        @(posedge clk) disable iff (rst)
        st.ctl2[5] |=> fin2 == 8'h00 && sec2 == 7'h00;
    endproperty
    a_clear_holds: assert property (p_clear_holds)
        else $error("timer two chains not cleared");

    // stopped timer freezes
    property p_freeze;
        @(posedge clk) disable iff (rst)
        !st.ctl1[6] && !st.ctl1[5] |=> $stable(fin1) && $stable(sec1);
    endproperty
    a_freeze: assert property (p_freeze)
        else $error("timer one advanced while stopped");

    // secondary chain stays below 100
    property p_sec_range;
        @(posedge clk) disable iff (rst)
        sec1 <= 7'h63 && sec2 <= 7'h63;
    endproperty
    a_sec_range: assert property (p_sec_range)
        else $error("secondary chain out of range");

    // routing to input one follows mask and destination
    property p_route;
        @(posedge clk) disable iff (rst)
        ##1 mcu_irq_one == $past(want_one);
    endproperty
    a_route: assert property (p_route)
        else $error("input one routing wrong");

    // routing to input zero follows mask and destination
    property p_route_zero;
        @(posedge clk) disable iff (rst)
        ##1 mcu_irq_zero == $past(want_zero);
    endproperty
    a_route_zero: assert property (p_route_zero)
        else $error("input zero routing wrong");

    // timer interrupt delivered holds dma off
    property p_dma_hold;
        @(posedge clk) disable iff (rst)
        routed[dit_pkg::SRC_TIMER_ONE] || routed[dit_pkg::SRC_TIMER_TWO]
            |=> dma_suspend;
    endproperty
    a_dma_hold: assert property (p_dma_hold)
        else $error("dma not suspended on timer interrupt");

    // written one forces the status bit
    property p_force;
        @(posedge clk) disable iff (rst)
        s_req ##0 (avs_write && wr_ok && idx == dit_pkg::IDX_STATUS)
            |=> (status & $past(wbyte)) == $past(wbyte);
    endproperty
    a_force: assert property (p_force)
        else $error("written status bit not forced");

    // bus answer one cycle after request
    sequence s_req;
        st.bus == DIT_IDLE && (avs_read || avs_write);
    endsequence
    property p_answer;
        @(posedge clk) disable iff (rst)
        s_req |=> !avs_waitrequest ##1 avs_waitrequest;
    endproperty
    a_answer: assert property (p_answer)
        else $error("bus answer timing wrong");
endmodule : dit_top
`default_nettype wire

// ==== dit_pkg.sv ====
/*
 register map, field positions, reset values and timing counts for the
 dual interval timer and interrupt router.
 assumes a 40 MHz system clock and byte-wide registers on 32-bit words.
*/
`default_nettype none
package dit_pkg;
    // clock and base tick
    localparam int CLK_HZ           = 40000000;   // system clock rate
    localparam int BASE_TICK_NS     = 5000;       // base tick period, 5 us
    localparam int CLK_PERIOD_NS    = 1000000000 / CLK_HZ;
    localparam int BASE_DIV         = BASE_TICK_NS / CLK_PERIOD_NS;
    localparam int SEC_DIV          = 100;        // secondary chain modulus
    localparam logic [6:0] SEC_LAST = 7'h63;      // last value before wrap
    // printed register offsets, kept as word indices
    localparam logic [15:0] IDX_STATUS      = 16'hFE04;
    localparam logic [15:0] IDX_T1_CTRL     = 16'hFE05;
    localparam logic [15:0] IDX_T1_THRESH   = 16'hFE06;
    localparam logic [15:0] IDX_T1_SEC      = 16'hFE07;
    localparam logic [15:0] IDX_T1_FINAL    = 16'hFE08;
    localparam logic [15:0] IDX_T2_CTRL     = 16'hFE09;
    localparam logic [15:0] IDX_T2_THRESH   = 16'hFE0A;
    localparam logic [15:0] IDX_T2_SEC      = 16'hFE0B;
    localparam logic [15:0] IDX_T2_FINAL    = 16'hFE0C;
    localparam logic [15:0] IDX_MASK        = 16'hFE0D;
    localparam logic [15:0] IDX_DEST        = 16'hFE0E;
    // control register fields
    localparam int CTL_EXPIRED   = 7;
    localparam int CTL_RUN       = 6;
    localparam int CTL_CLEAR     = 5;
    localparam int CTL_PRESCALE  = 4;
    localparam int CTL_IRQ_EN    = 0;
    localparam logic [7:0] CTL_WR_MASK = 8'h71;   // writable control bits
    // status bit positions of the two timers and the dma source
    localparam int SRC_TIMER_TWO = 3;
    localparam int SRC_TIMER_ONE = 2;
    localparam int SRC_DMA       = 4;
    // reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [6:0] RST_SEC  = 7'h00;
endpackage : dit_pkg
`default_nettype wire

// ==== dit_timer.sv ====
/*
 one interval timer: secondary divide-by-100 chain, 8-bit final chain,
 threshold compare and expired flag.
 assumes a one-cycle base tick strobe from a shared primary prescaler.
*/
`timescale 1ns/1ps
`default_nettype none
module dit_timer (
    input  wire logic       clk,          // system clock
    input  wire logic       rst,          // synchronous reset
    input  wire logic       base_tick,    // 5 us strobe
    input  wire logic       run_bit,      // chains may advance
    input  wire logic       clear_bit,    // chains held cleared
    input  wire logic       prescale_sel, // use secondary chain
    input  wire logic [7:0] threshold,    // timeout in steps
    output logic      [6:0] sec_count,    // secondary chain
    output logic      [7:0] final_count,  // final chain
    output logic            expired,      // sticky expired flag
    output logic            expire_pulse  // one cycle on expiry
);
    // all timer state
    typedef struct packed {
        logic [6:0] sec;
        logic [7:0] fin;
        logic       exp;
        logic       pulse;
    } dit_tmr_type;

    dit_tmr_type st;       // registered state
    dit_tmr_type next_st;  // next state
    logic        step;     // final chain advance strobe
    logic [7:0]  next_fin; // final chain after a step

    // chain advance and compare
    always_comb begin
        next_st       = st;
        next_st.pulse = 1'b0;
        step          = 1'b0;
        next_fin      = st.fin + 8'h01;
        if (clear_bit) begin
            // held cleared, flag withdrawn
            next_st.sec = dit_pkg::RST_SEC;
            next_st.fin = dit_pkg::RST_BYTE;
            next_st.exp = 1'b0;
        end else if (run_bit && base_tick) begin
            if (prescale_sel) begin
                // divide by 100 before the final chain
                if (st.sec == dit_pkg::SEC_LAST) begin
                    next_st.sec = dit_pkg::RST_SEC;
                    step        = 1'b1;
                end else begin
                    next_st.sec = st.sec + 7'h01;
                end
            end else begin
                // secondary bypassed
                step = 1'b1;
            end
        end
        if (step) begin
            next_st.fin = next_fin;
            // zero threshold matches after wrap: 256 steps
            if (next_fin == threshold) begin
                next_st.exp   = 1'b1;
                next_st.pulse = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign sec_count    = st.sec;
    assign final_count  = st.fin;
    assign expired      = st.exp;
    assign expire_pulse = st.pulse;
endmodule : dit_timer
`default_nettype wire

// ==== dit_core_model.sv ====
/*
 core side model: counts wake-ups on the two external interrupt inputs.
 assumes the inputs are levels registered on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dit_core_model (
    input  wire logic       clk,      // system clock
    input  wire logic       rst,      // synchronous reset
    input  wire logic       irq_zero, // external interrupt input 0
    input  wire logic       irq_one,  // external interrupt input 1
    output logic      [7:0] wakes     // new requests seen
);
    logic [1:0] prev; // levels one cycle back
    // a rising level on either input wakes the core once
    always_ff @(posedge clk) begin
        if (rst) begin
            prev  <= 2'h0;
            wakes <= 8'h00;
        end else begin
            prev  <= {irq_one, irq_zero};
            wakes <= wakes + 8'(|({irq_one, irq_zero} & ~prev));
        end
    end
endmodule : dit_core_model
`default_nettype wire

// ==== tb_dual_interval_timer_irq_router.sv ====
/*
 self-checking bench for the dual timer and interrupt router.
 assumes the avalon answer and register map given in the package.
*/
`timescale 1ns/1ps
`default_nettype none
`define DIT_CHECK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin \
    miscompares++; $display("wrong value at %0t: %s", $time, msg); end end
module tb_dual_interval_timer_irq_router;
    typedef struct {
        logic [31:0] data; // expected value
        logic [1:0]  resp; // expected response
        logic        full; // compare data too
    } dit_note_type;
    logic        clk;            // 40 MHz clock
    logic        rst;            // synchronous reset
    logic [17:0] avs_address;    // byte address
    logic        avs_read;       // read request
    logic        avs_write;      // write request
    logic [31:0] avs_writedata;  // write data
    logic [3:0]  avs_byteenable; // byte lanes
    logic [31:0] avs_readdata;   // read data
    logic        avs_waitrequest; // stall
    logic [1:0]  avs_response;   // response code
    logic [7:0]  source_irq;     // other sources
    logic        mcu_irq_zero;   // core input 0
    logic        mcu_irq_one;    // core input 1
    logic        dma_suspend;    // dma hold
    logic [7:0]  wakes;          // core wake count
    logic [7:0]  rdat;           // last read byte
    logic [7:0]  r0;             // saved reading
    logic        pin_req;        // ask monitor to look at pins
    logic [7:0]  m, d, s;        // random mask, dest, sources
    int          miscompares;    // mismatches
    int          n_tests;        // comparisons
    int          seed;           // seed result
    dit_note_type notes[$];      // expected results in order
    dit_note_type nt;            // note under compare
    localparam logic [15:0] REGS [11] = '{dit_pkg::IDX_STATUS,
        dit_pkg::IDX_T1_CTRL, dit_pkg::IDX_T1_THRESH, dit_pkg::IDX_T1_SEC,
        dit_pkg::IDX_T1_FINAL, dit_pkg::IDX_T2_CTRL, dit_pkg::IDX_T2_THRESH,
        dit_pkg::IDX_T2_SEC, dit_pkg::IDX_T2_FINAL, dit_pkg::IDX_MASK,
        dit_pkg::IDX_DEST};

    dit_top dit_top_i (.clk(clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .source_irq(source_irq),
        .mcu_irq_zero(mcu_irq_zero), .mcu_irq_one(mcu_irq_one),
        .dma_suspend(dma_suspend));
    dit_core_model dit_core_model_i (.clk(clk), .rst(rst),
        .irq_zero(mcu_irq_zero), .irq_one(mcu_irq_one), .wakes(wakes));

    // free-running clock, 25 ns period
    always #12.5 clk = ~clk;

    // monitor: each finished read or pin look takes the oldest note
    always @(posedge clk) begin
        if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
            nt = notes.pop_front();
            `DIT_CHECK(avs_response, nt.resp, "response")
            if (nt.full) `DIT_CHECK(avs_readdata, nt.data, "read data")
        end
        if (pin_req === 1'b1) begin
            nt = notes.pop_front();
            `DIT_CHECK({29'h0, dma_suspend, mcu_irq_one, mcu_irq_zero},
                       nt.data, "interrupt lines")
        end
    end

    // verdict and end of run
    task automatic end_of_test();
        if (miscompares == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test

    // one avalon access, held until waitrequest is seen low
    task automatic xfer(input logic w, input logic [15:0] idx,
                        input logic [7:0] wd);
        int n;
        @(posedge clk);
        avs_address   <= {idx, 2'b00};
        avs_write     <= w;
        avs_read      <= ~w;
        avs_writedata <= {24'h0, wd};
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (n == 50) begin
            miscompares++;
            end_of_test();
        end
        rdat = avs_readdata[7:0];
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask : xfer

    // write a register
    task automatic wr(input logic [15:0] idx, input logic [7:0] wd);
        xfer(1'b1, idx, wd);
    endtask : wr

    // read a register, noting what should come back
    task automatic rd(input logic [15:0] idx, input logic [7:0] ex,
                      input logic full = 1'b1, input logic [1:0] rs = 2'h0);
        notes.push_back('{{24'h0, ex}, rs, full});
        xfer(1'b0, idx, 8'h00);
    endtask : rd

    // note the expected {dma_suspend, irq_one, irq_zero}, then look
    task automatic pins(input logic [2:0] ex);
        notes.push_back('{{29'h0, ex}, 2'h0, 1'b1});
        @(posedge clk);
        pin_req <= 1'b1;
        @(posedge clk);
        pin_req <= 1'b0;
    endtask : pins

    // routed level of each core input and dma hold from status
    function automatic logic [2:0] route(input logic [7:0] st, mk, ds);
        return {|(st & mk & 8'h0C), |(st & mk & ds), |(st & mk & ~ds)};
    endfunction : route

    // main sequence
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        avs_address = 18'h0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        source_irq = 8'h00;
        pin_req = 1'b0;
        miscompares = 0;
        n_tests = 0;
        seed = $urandom(32'h9B2F);
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // reset values of the whole map, then an unmapped place
        foreach (REGS[i]) rd(REGS[i], 8'h00);
        rd(16'hFE0F, 8'h00, 1'b0, 2'h2);
        pins(3'h0);
        // control: read-only bits ignore writes
        wr(dit_pkg::IDX_T1_CTRL, 8'hFF);
        rd(dit_pkg::IDX_T1_CTRL, dit_pkg::CTL_WR_MASK);
        wr(dit_pkg::IDX_T1_CTRL, 8'h00);
        // write without the low lane is dropped
        avs_byteenable <= 4'hE;
        wr(dit_pkg::IDX_T1_THRESH, 8'h55);
        avs_byteenable <= 4'hF;
        rd(dit_pkg::IDX_T1_THRESH, 8'h00);
        // random mask, destination and sources
        repeat (8) begin
            m = 8'($urandom);
            d = 8'($urandom);
            s = 8'($urandom);
            source_irq <= s;
            wr(dit_pkg::IDX_MASK, m);
            wr(dit_pkg::IDX_DEST, d);
            rd(dit_pkg::IDX_MASK, m);
            rd(dit_pkg::IDX_STATUS, s & 8'hF3);
            pins(route(s & 8'hF3, m, d));
        end
        // forced status bit, removed only as forced
        source_irq <= 8'h01;
        wr(dit_pkg::IDX_STATUS, 8'h21);
        rd(dit_pkg::IDX_STATUS, 8'h21);
        wr(dit_pkg::IDX_STATUS, 8'h00);
        rd(dit_pkg::IDX_STATUS, 8'h01);
        source_irq <= 8'h00;
        wr(dit_pkg::IDX_MASK, 8'h0C);
        wr(dit_pkg::IDX_DEST, 8'h08);
        // timer one, 5 us steps, threshold 3
        r0 = wakes;
        wr(dit_pkg::IDX_T1_THRESH, 8'h03);
        wr(dit_pkg::IDX_T1_CTRL, 8'h41);
        repeat (350) @(posedge clk);
        rd(dit_pkg::IDX_T1_CTRL, 8'h41);
        repeat (300) @(posedge clk);
        rd(dit_pkg::IDX_T1_CTRL, 8'hC1);
        rd(dit_pkg::IDX_STATUS, 8'h04);
        pins(3'h5);
        `DIT_CHECK(wakes, r0 + 8'h01, "core wake-ups")
        // stopped chain holds still
        wr(dit_pkg::IDX_T1_CTRL, 8'h01);
        rd(dit_pkg::IDX_T1_FINAL, 8'h00, 1'b0);
        r0 = rdat;
        repeat (500) @(posedge clk);
        rd(dit_pkg::IDX_T1_FINAL, r0);
        // clear held: chain zero, flag and request dropped
        wr(dit_pkg::IDX_T1_CTRL, 8'h61);
        repeat (450) @(posedge clk);
        rd(dit_pkg::IDX_T1_FINAL, 8'h00);
        rd(dit_pkg::IDX_T1_CTRL, 8'h61);
        rd(dit_pkg::IDX_STATUS, 8'h00);
        pins(3'h0);
        // timer two expires without enable: flag only
        wr(dit_pkg::IDX_T2_THRESH, 8'h02);
        wr(dit_pkg::IDX_T2_CTRL, 8'h40);
        repeat (650) @(posedge clk);
        rd(dit_pkg::IDX_T2_CTRL, 8'hC0);
        rd(dit_pkg::IDX_STATUS, 8'h00);
        // threshold zero waits 256 steps
        wr(dit_pkg::IDX_T2_CTRL, 8'h20);
        wr(dit_pkg::IDX_T2_THRESH, 8'h00);
        wr(dit_pkg::IDX_T2_CTRL, 8'h41);
        repeat (50750) @(posedge clk);
        rd(dit_pkg::IDX_T2_CTRL, 8'h41);
        repeat (550) @(posedge clk);
        rd(dit_pkg::IDX_T2_CTRL, 8'hC1);
        rd(dit_pkg::IDX_STATUS, 8'h08);
        pins(3'h6);
        // timer one through the divide-by-100 stage
        wr(dit_pkg::IDX_T1_CTRL, 8'h20);
        wr(dit_pkg::IDX_T1_THRESH, 8'h01);
        wr(dit_pkg::IDX_T1_CTRL, 8'h51);
        repeat (2100) @(posedge clk);
        rd(dit_pkg::IDX_T1_SEC, 8'h00, 1'b0);
        `DIT_CHECK(rdat > 8'h05 && rdat < 8'h64, 1'b1, "secondary")
        rd(dit_pkg::IDX_T1_FINAL, 8'h00);
        repeat (17000) @(posedge clk);
        rd(dit_pkg::IDX_T1_CTRL, 8'h51);
        repeat (1300) @(posedge clk);
        rd(dit_pkg::IDX_T1_CTRL, 8'hD1);
        rd(dit_pkg::IDX_T1_FINAL, 8'h01);
        end_of_test();
    end
endmodule : tb_dual_interval_timer_irq_router
`default_nettype wire
